/* File: design/lfs_defines.svh */
`ifndef LFS_DEFINES_SVH
`define LFS_DEFINES_SVH

// Register addresses on the internal register port.
`define LFS_ADDR_GEN_HI      8'h30
`define LFS_ADDR_GEN_LO      8'h31
`define LFS_ADDR_GND_SHORT   8'h35
`define LFS_ADDR_STR_SHORT   8'h37
`define LFS_ADDR_LATCH_FIRST 8'h38
`define LFS_ADDR_LATCH_LAST  8'h43

// Field positions and sizes.
`define LFS_NUM_CH           8
`define LFS_NUM_GEN          12
`define LFS_NUM_LATCH        12
`define LFS_NUM_AUX          8
`define LFS_FS_GND_BIT       9
`define LFS_FS_STR_BIT       11
`define LFS_LATCH_GEN_LO     0
`define LFS_LATCH_GEN_HI     1
`define LFS_LATCH_GND        2
`define LFS_LATCH_STR        3
`define LFS_LATCH_AUX0       4

// Reset and unmapped read values.
`define LFS_REG_RESET        8'h00
`define LFS_UNMAPPED_DATA    8'h00

`endif

/* File: design/lfs_pkg.sv */
`include "lfs_defines.svh"

package lfs_pkg;

	typedef struct packed {
		logic [`LFS_NUM_LATCH-1:0][7:0]	latched;
		logic [`LFS_NUM_GEN-1:0]		gen_fault;
		logic [`LFS_NUM_CH-1:0]			gnd_short_flag;
		logic [`LFS_NUM_CH-1:0]			string_short_flag;
		logic [7:0]						rd_data;
		logic							rd_valid;
		logic							init_halt;
		logic							fault_o;
		logic							fault_oe_n;
	} lfs_state_t;

	typedef struct packed {
		logic [`LFS_NUM_AUX-1:0][7:0]	aux_fault;
		logic [`LFS_NUM_GEN-1:0]		ext_fault;
		logic [`LFS_NUM_CH-1:0]			above_thresh;
		logic [`LFS_NUM_CH-1:0]			pin_at_gnd;
		logic							startup_active;
	} lfs_pins_t;

endpackage : lfs_pkg

/* File: design/lfs_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module lfs_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input  wire logic				ref_clk,
	input  wire logic				resetn,
	// Data.
	input  wire logic [WIDTH-1:0]	async_in,
	output logic [WIDTH-1:0]		sync_out
);

	logic [WIDTH-1:0]	meta;

	// The first stage feeds only the second stage.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			meta     <= '0;
			sync_out <= '0;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end

endmodule // lfs_sync

`default_nettype wire

/* File: design/lfs_status_regs.sv */
// Summary of operation
// - A channel's ground-short flag (bit 7 = channel 8 .. bit 0 = channel 1) sets when its pin stays at ground during startup.
// - Any ground-short flag seen during startup halts further initialization.
// - Any set ground-short flag raises general fault 10 (general status bit 9).
// - A channel's string-short flag (bit 7 = channel 8 .. bit 0 = channel 1) sets when its pin is above its threshold.
// - Any set string-short flag raises general fault 12 (general status bit 11).
// - The latched registers at 0x38 to 0x43 keep a record of every fault seen until read.
// - Reading a latched register returns its content and then clears every bit whose event is not present in that same cycle.
// - The ground-short and string-short registers are read only and reset to zero.
// - Any general fault pulls the open-drain fault alert pin low.
`timescale 1ns/1ps
`default_nettype none

`include "lfs_defines.svh"

module lfs_status_regs
	import lfs_pkg::*;
(
	// Clock and reset.
	input  wire logic						ref_clk,
	input  wire logic						resetn,
	// Analog fault comparators and power-on sequencer, asynchronous.
	input  wire logic						startup_active,
	input  wire logic [`LFS_NUM_CH-1:0]		pin_at_gnd,
	input  wire logic [`LFS_NUM_CH-1:0]		above_thresh,
	input  wire logic [`LFS_NUM_GEN-1:0]	ext_fault,
	input  wire logic [`LFS_NUM_AUX*8-1:0]	aux_fault,
	// Register read port from the serial interface logic.
	input  wire logic						reg_rd_req,
	input  wire logic [7:0]					reg_addr,
	output logic [7:0]						reg_rd_data,
	output logic							reg_rd_valid,
	// Sequencer control and fault alert pin.
	output logic							init_halt,
	output logic							fault_o,
	output logic							fault_oe_n
);

	lfs_pins_t	pins_raw;
	lfs_pins_t	pins;
	lfs_state_t	state;
	lfs_state_t	next_state;

	function automatic logic is_latched(input logic [7:0] addr);
		is_latched = (addr >= `LFS_ADDR_LATCH_FIRST) && (addr <= `LFS_ADDR_LATCH_LAST);
	endfunction

	function automatic logic [3:0] latch_index(input logic [7:0] addr);
		logic [7:0] diff;
		diff        = addr - `LFS_ADDR_LATCH_FIRST;
		latch_index = diff[3:0];
	endfunction

	assign pins_raw.startup_active = startup_active;
	assign pins_raw.pin_at_gnd     = pin_at_gnd;
	assign pins_raw.above_thresh   = above_thresh;
	assign pins_raw.ext_fault      = ext_fault;
	assign pins_raw.aux_fault      = aux_fault;

	lfs_sync #(
		.WIDTH($bits(lfs_pins_t))
	) u_sync (
		.ref_clk	(ref_clk),
		.resetn		(resetn),
		.async_in	(pins_raw),
		.sync_out	(pins)
	);

	logic [`LFS_NUM_LATCH-1:0][7:0]	latch_set;
	logic [`LFS_NUM_LATCH-1:0]		latch_clr;

	always_comb begin
		next_state = state;
		latch_set  = '0;
		// Ground-short flags are sticky, since the sequencer stops on them anyway.
		next_state.gnd_short_flag = state.gnd_short_flag
			| (pins.pin_at_gnd & {`LFS_NUM_CH{pins.startup_active}});
		next_state.string_short_flag = pins.above_thresh;
		next_state.init_halt = state.init_halt | (|next_state.gnd_short_flag);
		next_state.gen_fault = pins.ext_fault;
		next_state.gen_fault[`LFS_FS_GND_BIT] = pins.ext_fault[`LFS_FS_GND_BIT]
			| (|next_state.gnd_short_flag);
		next_state.gen_fault[`LFS_FS_STR_BIT] = pins.ext_fault[`LFS_FS_STR_BIT]
			| (|next_state.string_short_flag);
		next_state.fault_o    = 1'b0;
		next_state.fault_oe_n = ~(|next_state.gen_fault);

		// Read data is captured from the current value, then a latched register clears.
		next_state.rd_valid = reg_rd_req;
		next_state.rd_data  = state.rd_data;
		if (reg_rd_req) begin
			case (reg_addr)
				`LFS_ADDR_GEN_HI:    next_state.rd_data = {4'h0, state.gen_fault[11:8]};
				`LFS_ADDR_GEN_LO:    next_state.rd_data = state.gen_fault[7:0];
				`LFS_ADDR_GND_SHORT: next_state.rd_data = state.gnd_short_flag;
				`LFS_ADDR_STR_SHORT: next_state.rd_data = state.string_short_flag;
				default: begin
					if (is_latched(reg_addr)) begin
						next_state.rd_data = state.latched[latch_index(reg_addr)];
					end else begin
						next_state.rd_data = `LFS_UNMAPPED_DATA;
					end
				end
			endcase
		end

		// Event sources are taken in this same process, so the flag logic and the record never form a loop.
		latch_set[`LFS_LATCH_GEN_LO] = next_state.gen_fault[7:0];
		latch_set[`LFS_LATCH_GEN_HI] = {4'h0, next_state.gen_fault[11:8]};
		latch_set[`LFS_LATCH_GND]    = next_state.gnd_short_flag;
		latch_set[`LFS_LATCH_STR]    = next_state.string_short_flag;
		for (int i = 0; i < `LFS_NUM_AUX; i++) begin
			latch_set[`LFS_LATCH_AUX0 + i] = pins.aux_fault[i];
		end

		// A new event in the clearing cycle survives the clear.
		for (int i = 0; i < `LFS_NUM_LATCH; i++) begin
			latch_clr[i] = reg_rd_req && is_latched(reg_addr) && (latch_index(reg_addr) == 4'(i));
			next_state.latched[i] = (state.latched[i] & ~{8{latch_clr[i]}}) | latch_set[i];
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state <= '{latched: '0, gen_fault: '0, gnd_short_flag: `LFS_REG_RESET,
				string_short_flag: `LFS_REG_RESET, rd_data: `LFS_REG_RESET, rd_valid: 1'b0,
				init_halt: 1'b0, fault_o: 1'b0, fault_oe_n: 1'b1};
		end else begin
			state <= next_state;
		end
	end

	assign reg_rd_data  = state.rd_data;
	assign reg_rd_valid = state.rd_valid;
	assign init_halt    = state.init_halt;
	assign fault_o      = state.fault_o;
	assign fault_oe_n   = state.fault_oe_n;

	property p_gnd_set;
		@(posedge ref_clk) disable iff (!resetn)
		(pins.startup_active && pins.pin_at_gnd != 8'h00) |=> ((state.gnd_short_flag & $past(pins.pin_at_gnd)) != 8'h00);
	endproperty
	a_gnd_set: assert property (p_gnd_set) else $error("ground-short flag not set");

	property p_halt;
		@(posedge ref_clk) disable iff (!resetn)
		(state.gnd_short_flag != 8'h00) |-> state.init_halt;
	endproperty
	a_halt: assert property (p_halt) else $error("init not halted on ground short");

	property p_fs10;
		@(posedge ref_clk) disable iff (!resetn)
		(state.gnd_short_flag != 8'h00) |-> state.gen_fault[9];
	endproperty
	a_fs10: assert property (p_fs10) else $error("general fault 10 missing");

	property p_str_follow;
		@(posedge ref_clk) disable iff (!resetn)
		##1 state.string_short_flag == $past(pins.above_thresh);
	endproperty
	a_str_follow: assert property (p_str_follow) else $error("string-short flag not live");

	property p_fs12;
		@(posedge ref_clk) disable iff (!resetn)
		(state.string_short_flag != 8'h00) |-> state.gen_fault[11];
	endproperty
	a_fs12: assert property (p_fs12) else $error("general fault 12 missing");

	property p_keep;
		@(posedge ref_clk) disable iff (!resetn)
		(!reg_rd_req && state.latched[2] != 8'h00) |=> ((state.latched[2] & $past(state.latched[2])) == $past(state.latched[2]));
	endproperty
	a_keep: assert property (p_keep) else $error("latched record lost without read");

	property p_rc;
		@(posedge ref_clk) disable iff (!resetn)
		(reg_rd_req && reg_addr == 8'h3B && pins.above_thresh == 8'h00)
			|=> (reg_rd_valid && reg_rd_data == $past(state.latched[3]) && state.latched[3] == 8'h00);
	endproperty
	a_rc: assert property (p_rc) else $error("latched read did not return then clear");

	property p_ro;
		@(posedge ref_clk) disable iff (!resetn)
		(reg_rd_req && reg_addr == 8'h35) |=> (reg_rd_valid && reg_rd_data == $past(state.gnd_short_flag));
	endproperty
	a_ro: assert property (p_ro) else $error("ground-short read wrong");

	property p_alert;
		@(posedge ref_clk) disable iff (!resetn)
		(state.gen_fault != 12'h000) |-> (!fault_oe_n && !fault_o);
	endproperty
	a_alert: assert property (p_alert) else $error("fault pin not pulled low");

	property p_alert_clear;
		@(posedge ref_clk) disable iff (!resetn)
		(state.gen_fault == 12'h000) |-> (fault_oe_n && !fault_o);
	endproperty
	a_alert_clear: assert property (p_alert_clear) else $error("fault pin pulled low without fault");

	property p_valid;
		@(posedge ref_clk) disable iff (!resetn)
		1'b1 |=> (reg_rd_valid == $past(reg_rd_req));
	endproperty
	a_valid: assert property (p_valid) else $error("read valid not one cycle after request");

	property p_gnd_sticky;
		@(posedge ref_clk) disable iff (!resetn)
		1'b1 |=> ((state.gnd_short_flag & $past(state.gnd_short_flag)) == $past(state.gnd_short_flag));
	endproperty
	a_gnd_sticky: assert property (p_gnd_sticky) else $error("ground-short flag dropped");

	property p_gnd_hold;
		@(posedge ref_clk) disable iff (!resetn)
		(!pins.startup_active) |=> (state.gnd_short_flag == $past(state.gnd_short_flag));
	endproperty
	a_gnd_hold: assert property (p_gnd_hold) else $error("ground-short flag set outside startup");

	property p_halt_sticky;
		@(posedge ref_clk) disable iff (!resetn)
		state.init_halt |=> state.init_halt;
	endproperty
	a_halt_sticky: assert property (p_halt_sticky) else $error("init halt released");

	property p_set_wins;
		@(posedge ref_clk) disable iff (!resetn)
		(state.gnd_short_flag != 8'h00) |=> ((state.latched[2] & $past(state.gnd_short_flag)) == $past(state.gnd_short_flag));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("standing ground fault cleared from record");

endmodule // lfs_status_regs

`default_nettype wire

/* File: bench/lfs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module lfs_host_model (
	// Clock.
	input  wire logic		ref_clk,
	// Register read port.
	output logic			reg_rd_req,
	output logic [7:0]		reg_addr,
	input  wire logic [7:0]	reg_rd_data,
	input  wire logic		reg_rd_valid
);
	initial begin
		reg_rd_req = 1'b0;
		reg_addr = 8'h00;
	end

	// The address is inverted while idle so nothing can lean on a stale value.
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(negedge ref_clk);
		reg_rd_req = 1'b1;
		reg_addr = a;
		@(posedge ref_clk);
		@(negedge ref_clk);
		reg_rd_req = 1'b0;
		reg_addr = ~a;
		ok = reg_rd_valid;
		d = reg_rd_data;
	endtask
endmodule // lfs_host_model

`default_nettype wire

/* File: bench/led_fault_status_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module led_fault_status_regs_tb_top;
	logic			ref_clk = 1'b0, resetn = 1'b0, startup_active = 1'b0;
	logic [7:0]		pin_at_gnd = 8'h00, above_thresh = 8'h00, d, r, v;
	logic [11:0]	ext_fault = 12'h000, e;
	logic [63:0]	aux_fault = 64'h0;
	logic			reg_rd_req, reg_rd_valid, init_halt, fault_o, fault_oe_n, ok;
	logic [7:0]		reg_addr, reg_rd_data;
	int				bad_count = 0, comparisons = 0;

	always #50 ref_clk = ~ref_clk;

	lfs_status_regs i_dut (.ref_clk, .resetn, .startup_active, .pin_at_gnd, .above_thresh,
		.ext_fault, .aux_fault, .reg_rd_req, .reg_addr, .reg_rd_data, .reg_rd_valid,
		.init_halt, .fault_o, .fault_oe_n);
	lfs_host_model i_host (.ref_clk, .reg_rd_req, .reg_addr, .reg_rd_data, .reg_rd_valid);

	task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
		comparisons++;
		if (g !== x) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] x);
		i_host.rd(a, d, ok);
		chk("reg_rd_valid", 8'h01, {7'h00, ok});
		chk($sformatf("reg %h", a), x, d);
	endtask

	// Two edges through the synchronizer, one for the flag register and one spare.
	task automatic settle();
		repeat (4) @(negedge ref_clk);
	endtask

	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#(3000 * 100);
		bad_count++;
		test_done();
	end

	initial begin
		void'($urandom(32'h06CA));
		repeat (6) @(negedge ref_clk);
		resetn = 1'b1;
		// Gaps at 0x32 to 0x34, 0x36 and above 0x43 are unmapped and read as zero.
		for (int a = 8'h30; a < 8'h48; a++) rdchk(8'(a), 8'h00);
		chk("fault_oe_n", 8'h01, {7'h00, fault_oe_n});
		$display("test reset done");
		for (int k = 0; k < 4; k++) begin
			r = (k == 0) ? 8'h80 : 8'($urandom);
			above_thresh = r;
			settle();
			rdchk(8'h37, r);
			rdchk(8'h30, {4'h0, |r, 3'h0});
			chk("fault_oe_n", {7'h00, ~|r}, {7'h00, fault_oe_n});
			above_thresh = 8'h00;
			settle();
			rdchk(8'h37, 8'h00);
			rdchk(8'h3B, r);
			rdchk(8'h3B, 8'h00);
			rdchk(8'h39, {4'h0, |r, 3'h0});
		end
		$display("test string short done");
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? 8'hFF : 8'($urandom);
			e = 12'($urandom);
			aux_fault = 64'(v) << (8 * i);
			ext_fault = e;
			settle();
			rdchk(8'h31, e[7:0]);
			chk("fault_oe_n", {7'h00, ~|e}, {7'h00, fault_oe_n});
			aux_fault = 64'h0;
			ext_fault = 12'h000;
			settle();
			rdchk(8'(8'h3C + i), v);
			rdchk(8'(8'h3C + i), 8'h00);
			rdchk(8'h38, e[7:0]);
			rdchk(8'h39, {4'h0, e[11:8]});
		end
		$display("test latched record done");
		r = 8'($urandom) | 8'h01;
		pin_at_gnd = r;
		settle();
		rdchk(8'h35, 8'h00);
		chk("init_halt", 8'h00, {7'h00, init_halt});
		startup_active = 1'b1;
		settle();
		rdchk(8'h35, r);
		chk("init_halt", 8'h01, {7'h00, init_halt});
		rdchk(8'h30, 8'h02);
		chk("fault_oe_n", 8'h00, {7'h00, fault_oe_n});
		chk("fault_o", 8'h00, {7'h00, fault_o});
		pin_at_gnd = 8'h00;
		startup_active = 1'b0;
		settle();
		rdchk(8'h35, r);
		rdchk(8'h3A, r);
		// The ground flags still stand, so they set the record again in the clearing cycle.
		rdchk(8'h3A, r);
		$display("test ground short done");
		resetn = 1'b0;
		repeat (2) @(negedge ref_clk);
		chk("fault_oe_n", 8'h01, {7'h00, fault_oe_n});
		resetn = 1'b1;
		rdchk(8'h35, 8'h00);
		chk("init_halt", 8'h00, {7'h00, init_halt});
		rdchk(8'h3A, 8'h00);
		$display("test mid-run reset done");
		test_done();
	end
endmodule // led_fault_status_regs_tb_top

`default_nettype wire
